// [src/pbqm_pkg.sv]
// Constants, register map and state codes of the packet buffer manager.
// Assumes a 32-bit register bus and word-wide packet memory.
package pbqm_pkg;
	// Memory geometry
	localparam int NPKT = 16; // Packet numbers available
	localparam int PKT_W = 4; // Width of a packet number
	localparam int PAGE_SH = 6; // Words per page as a shift
	localparam int BYTE_SH = 8; // Bytes per page as a shift
	localparam int MAX_PAGES = 8; // Pages one packet may own
	localparam int PG_W = 4; // Width of a per-packet page count
	localparam int FREE_W = 8; // Width of the free page count
	localparam int WOFS_W = 10; // Logical word offset, with overflow bit
	localparam int ADDR_W = 13; // Physical word address width
	localparam logic [FREE_W-1:0] TOTAL_PAGES = 8'h80; // Whole memory

	// Fixed words at the head of every receive packet
	localparam logic [WOFS_W-1:0] STAT_WORD = 10'h000;
	localparam logic [WOFS_W-1:0] CNT_WORD = 10'h001;
	localparam logic [WOFS_W-1:0] DATA_WORD = 10'h002;

	// Register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_PNR = 8'h0C;
	localparam logic [7:0] REG_PORTS = 8'h10;
	localparam logic [7:0] REG_RSV = 8'h14;
	localparam logic [7:0] REG_FREE = 8'h18;
	localparam logic [7:0] REG_LINK = 8'h1C;

	// Control register bits
	localparam int CTRL_TXGO = 0;
	localparam int CTRL_RXGO = 1;
	localparam int CTRL_SELF = 2;
	localparam int CTRL_RXIE = 3;
	localparam int CTRL_HALF = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [FREE_W-1:0] RSV_RST = 8'h00;

	// Status register bits
	localparam int ST_ALLOC = 0;
	localparam int ST_TXDONE = 1;
	localparam int ST_DRAIN = 2;
	localparam int ST_RXRDY = 3;
	localparam int ST_AFAIL = 4;
	localparam int ST_ARES = 8;

	// Queue port register fields
	localparam int PO_TXH = 0;
	localparam int PO_TXE = 7;
	localparam int PO_RXH = 8;
	localparam int PO_RXE = 15;

	// Command register: code in low bits, byte length above
	localparam int CMD_LEN = 16;
	localparam logic [2:0] CMD_ALLOC = 3'h1;
	localparam logic [2:0] CMD_ENQ = 3'h2;
	localparam logic [2:0] CMD_RXREL = 3'h3;
	localparam logic [2:0] CMD_REL = 3'h4;
	localparam logic [2:0] CMD_TXACK = 3'h5;

	// Receive sequencer states
	typedef enum logic [4:0] {
		R_IDLE = 5'b00001,
		R_DATA = 5'b00010,
		R_DROP = 5'b00100,
		R_STAT = 5'b01000,
		R_CNT = 5'b10000
	} rx_st_e;
endpackage : pbqm_pkg

// [src/pkt_queue.sv]
// Queue of packet numbers with push and pop in the same cycle.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
module pkt_queue #(
	parameter int W = 4,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic push_i,
	input wire logic [W-1:0] data_i,
	input wire logic pop_i,
	output logic [W-1:0] data_o,
	output logic empty_o,
	output logic full_o
);
	logic [W-1:0] mem_q [DEPTH]; // Entry storage
	logic [AW-1:0] wp_q; // Write index
	logic [AW-1:0] rp_q; // Read index
	logic [AW:0] cnt_q; // Entries held

	// Storage needs no reset; the indices define contents
	always_ff @(posedge clk_i) begin
		if (ce_i && push_i) begin
			mem_q[wp_q] <= data_i;
		end
	end

	// Indices and fill count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			if (push_i) begin
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pop_i) begin
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, push_i} - {{AW{1'b0}}, pop_i};
		end
	end

	assign data_o = mem_q[rp_q];
	assign empty_o = (cnt_q == '0);
	assign full_o = (cnt_q == (AW+1)'(DEPTH));
endmodule : pkt_queue

// [src/pbqm_top.sv]
// Packet buffer manager: allocation, transmit and receive queues.
// Assumes an AHB-Lite master and a MAC engine synchronous to clk_i.
// Function
// - Allocate command reserves memory, reports packet number
// - Enqueue copies packet number into transmit queue
// - Transmit only with go bit and deferral
// - Self-free skips completion queue, frees pages
// - Done flag while completion queue non-empty
// - Drained flag while transmit queue empty
// - Failure: done flag, clear go, present number
// - Oldest completed number shown at queue port
// - Frames accepted only with receive go bit
// - Receive obtains number, extra pages when needed
// - Sequential logical addresses mapped to physical
// - Receive overrun drops frame, returns memory
// - Status word first, byte count second
// - Good CRC pushes number to receive queue
// - Bad CRC frees memory, no receive flag
// - Ready flag: receive queue non-empty and enabled
// - Remove-release pops head, frees its memory
// - Below reservation receive allocations fail
// - Zero reservation: whole memory first-come
// - Raised reservation spares frames in progress
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pbqm_top import pbqm_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic tx_req_o,
	output logic [PKT_W-1:0] tx_pkt_o,
	input wire logic tx_defer_ok_i,
	input wire logic tx_done_i,
	input wire logic tx_ok_i,
	input wire logic [15:0] tx_status_i,
	input wire logic rx_start_i,
	input wire logic rx_word_valid_i,
	input wire logic [31:0] rx_word_i,
	input wire logic rx_end_i,
	input wire logic rx_crc_ok_i,
	input wire logic [15:0] rx_status_i,
	input wire logic [15:0] rx_bytes_i,
	output logic rx_drop_o,
	output logic mem_we_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic [31:0] mem_wdata_o
);
	// Register state
	logic [4:0] ctrl_q; // Go bits and options
	logic [PKT_W-1:0] pnr_q; // packet_number_reg
	logic [FREE_W-1:0] rsv_q; // Pages reserved for transmit
	logic [FREE_W-1:0] free_q; // Free pages
	logic [15:0] link_q; // link_side_status_reg
	logic alloc_done_q, alloc_fail_q; // Allocation result flags
	logic [PKT_W-1:0] ares_q; // Allocation result location
	logic tx_done_q, drain_q, rx_rdy_q; // Queue flags
	// Bus data phase
	logic wr_q; // Write data phase pending
	logic [7:0] waddr_q; // Its byte address
	logic [31:0] rd_d; // Read data for the address phase
	// Allocator
	logic pend_q; // Host allocation waiting
	logic [8:0] need_q; // Pages it needs
	logic [NPKT-1:0] used_q; // Packet numbers in use
	logic [PG_W-1:0] pages_q [NPKT]; // Pages owned per number
	logic [PKT_W-1:0] fnum; // Lowest free number
	logic fany; // Some number is free
	logic [NPKT-1:0] free_mask; // Numbers released this cycle
	logic [FREE_W-1:0] pg_back; // Pages they return
	logic [FREE_W-1:0] pg_take; // Pages granted this cycle
	logic a_try, a_ok; // Host allocation attempt and success
	// Transmit
	logic tx_busy_q; // Packet handed to the MAC
	logic tx_issue, tx_end; // Hand-off and completion events
	logic tq_empty, tq_full, dq_empty, dq_full;
	logic dq_push;
	logic [PKT_W-1:0] tq_head, dq_head;
	// Receive
	rx_st_e rst_q; // Receive sequencer
	logic [PKT_W-1:0] rx_pkt_q; // Number of the frame in progress
	logic [WOFS_W-1:0] wofs_q; // Logical word offset
	logic crc_q; // Latched frame verdict
	logic [15:0] rstat_q, rbytes_q;
	logic rx_take, rx_pg, rx_ovr, rx_word;
	logic rq_push, rq_empty, rq_full;
	logic [PKT_W-1:0] rq_head;
	// Decoded host commands
	logic cmd_wr;
	logic [2:0] cmd;
	logic c_enq, c_rxrel, c_rel, c_ack;

	assign cmd_wr = ce_i && wr_q && (waddr_q == REG_CMD);
	assign cmd = hwdata_i[2:0];
	assign c_enq = cmd_wr && (cmd == CMD_ENQ) && !tq_full;
	assign c_rxrel = cmd_wr && (cmd == CMD_RXREL) && !rq_empty;
	assign c_rel = cmd_wr && (cmd == CMD_REL) && used_q[pnr_q];
	assign c_ack = cmd_wr && (cmd == CMD_TXACK) && !dq_empty;

	// Bus slave: always ready, OKAY, read data taken at address phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= 1'b0;
			waddr_q <= 8'h00;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else if (ce_i) begin
			wr_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
			waddr_q <= haddr_i[7:0];
			if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
				hrdata_o <= rd_d;
			end
		end
	end

	// Read multiplexer; unmapped words read as zero
	always_comb begin
		rd_d = 32'h0000_0000;
		case (haddr_i[7:0])
			REG_CTRL: rd_d[4:0] = ctrl_q;
			REG_STAT: begin
				rd_d[ST_ALLOC] = alloc_done_q;
				rd_d[ST_TXDONE] = tx_done_q;
				rd_d[ST_DRAIN] = drain_q;
				rd_d[ST_RXRDY] = rx_rdy_q;
				rd_d[ST_AFAIL] = alloc_fail_q;
				rd_d[ST_ARES +: PKT_W] = ares_q;
			end
			REG_PNR: rd_d[PKT_W-1:0] = pnr_q;
			REG_PORTS: begin
				rd_d[PO_TXH +: PKT_W] = dq_head;
				rd_d[PO_TXE] = dq_empty;
				rd_d[PO_RXH +: PKT_W] = rq_head;
				rd_d[PO_RXE] = rq_empty;
			end
			REG_RSV: rd_d[FREE_W-1:0] = rsv_q;
			REG_FREE: rd_d[FREE_W-1:0] = free_q;
			REG_LINK: rd_d[15:0] = link_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// Software-written registers; a transmit failure beats a go write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
			pnr_q <= '0;
			rsv_q <= RSV_RST;
		end else if (ce_i) begin
			if (wr_q && waddr_q == REG_CTRL) begin
				ctrl_q <= hwdata_i[4:0];
			end
			if (wr_q && waddr_q == REG_PNR) begin
				pnr_q <= hwdata_i[PKT_W-1:0];
			end
			if (wr_q && waddr_q == REG_RSV) begin
				rsv_q <= hwdata_i[FREE_W-1:0];
			end
			if (tx_end && !tx_ok_i) begin
				ctrl_q[CTRL_TXGO] <= 1'b0;
			end
		end
	end

	// Lowest free packet number
	always_comb begin
		fnum = '0;
		fany = 1'b0;
		for (int i = NPKT - 1; i >= 0; i--) begin
			if (!used_q[i]) begin
				fnum = PKT_W'(i);
				fany = 1'b1;
			end
		end
	end

	// Host allocation waits a cycle when the receive side takes a number
	assign a_try = ce_i && pend_q && !rx_take;
	assign a_ok = a_try && fany && (need_q <= 9'(MAX_PAGES))
		&& (9'(free_q) >= need_q);

	// Host allocation request and its result flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q <= 1'b0;
			need_q <= '0;
			alloc_done_q <= 1'b0;
			alloc_fail_q <= 1'b0;
			ares_q <= '0;
		end else if (ce_i) begin
			if (cmd_wr && cmd == CMD_ALLOC) begin
				pend_q <= 1'b1;
				need_q <= 9'((17'(hwdata_i[31:CMD_LEN]) + 17'hFF) >> BYTE_SH);
				if (hwdata_i[31:CMD_LEN] == 16'h0000) begin
					need_q <= 9'h001;
				end
				alloc_done_q <= 1'b0;
				alloc_fail_q <= 1'b0;
			end else if (a_try) begin
				pend_q <= 1'b0;
				if (a_ok) begin
					alloc_done_q <= 1'b1;
					ares_q <= fnum;
				end else begin
					alloc_fail_q <= 1'b1;
				end
			end
		end
	end

	// Releases gathered from every source in this cycle
	always_comb begin
		free_mask = '0;
		pg_back = '0;
		if (tx_end && tx_ok_i && ctrl_q[CTRL_SELF]) begin
			free_mask[tx_pkt_o] = 1'b1;
		end
		if (rx_ovr || (rst_q == R_CNT && !crc_q)) begin
			free_mask[rx_pkt_q] = 1'b1;
		end
		if (c_rxrel) begin
			free_mask[rq_head] = 1'b1;
		end
		if (c_rel) begin
			free_mask[pnr_q] = 1'b1;
		end
		for (int i = 0; i < NPKT; i++) begin
			if (free_mask[i]) begin
				pg_back = pg_back + FREE_W'(pages_q[i]);
			end
		end
	end

	assign pg_take = (a_ok ? FREE_W'(need_q) : '0)
		+ {{FREE_W-1{1'b0}}, rx_take} + {{FREE_W-1{1'b0}}, rx_pg};

	// Ownership table and free page count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			used_q <= '0;
			free_q <= TOTAL_PAGES;
			for (int i = 0; i < NPKT; i++) begin
				pages_q[i] <= '0;
			end
		end else if (ce_i) begin
			free_q <= free_q - pg_take + pg_back;
			for (int i = 0; i < NPKT; i++) begin
				if (free_mask[i]) begin
					used_q[i] <= 1'b0;
					pages_q[i] <= '0;
				end
			end
			if (rx_take) begin
				used_q[fnum] <= 1'b1;
				pages_q[fnum] <= PG_W'(1);
			end else if (a_ok) begin
				used_q[fnum] <= 1'b1;
				pages_q[fnum] <= PG_W'(need_q);
			end
			if (rx_pg) begin
				pages_q[rx_pkt_q] <= pages_q[rx_pkt_q] + 1'b1;
			end
		end
	end

	// Transmit hand-off and completion
	assign tx_issue = ce_i && ctrl_q[CTRL_TXGO] && !tq_empty && !tx_busy_q
		&& (!ctrl_q[CTRL_HALF] || tx_defer_ok_i);
	assign tx_end = ce_i && tx_busy_q && tx_done_i;
	assign dq_push = tx_end && !(tx_ok_i && ctrl_q[CTRL_SELF]);

	// One packet at a time goes to the MAC
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_busy_q <= 1'b0;
			tx_req_o <= 1'b0;
			tx_pkt_o <= '0;
			link_q <= 16'h0000;
		end else if (ce_i) begin
			tx_req_o <= tx_issue;
			if (tx_issue) begin
				tx_busy_q <= 1'b1;
				tx_pkt_o <= tq_head;
			end else if (tx_end) begin
				tx_busy_q <= 1'b0;
				link_q <= tx_status_i;
			end
		end
	end

	// Queue flags follow queue contents one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_done_q <= 1'b0;
			drain_q <= 1'b1;
			rx_rdy_q <= 1'b0;
		end else if (ce_i) begin
			tx_done_q <= !dq_empty;
			drain_q <= tq_empty;
			rx_rdy_q <= !rq_empty && ctrl_q[CTRL_RXIE];
		end
	end

	// Receive events; later pages only need any free page, so frames
	// already running finish even if the reservation was raised
	assign rx_take = ce_i && rst_q == R_IDLE && rx_start_i
		&& ctrl_q[CTRL_RXGO] && fany && (free_q > rsv_q);
	assign rx_word = ce_i && rst_q == R_DATA && rx_word_valid_i;
	assign rx_ovr = rx_word && (wofs_q[WOFS_W-1]
		|| ({1'b0, wofs_q[WOFS_W-2:PAGE_SH]} == pages_q[rx_pkt_q]
		&& free_q == '0));
	assign rx_pg = rx_word && !rx_ovr
		&& {1'b0, wofs_q[WOFS_W-2:PAGE_SH]} == pages_q[rx_pkt_q];
	assign rq_push = ce_i && rst_q == R_CNT && crc_q;

	// Receive sequencer and packet memory writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_q <= R_IDLE;
			rx_pkt_q <= '0;
			wofs_q <= '0;
			crc_q <= 1'b0;
			rstat_q <= 16'h0000;
			rbytes_q <= 16'h0000;
			rx_drop_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= '0;
			mem_wdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			rx_drop_o <= rx_ovr;
			mem_we_o <= 1'b0;
			case (rst_q)
				R_IDLE: begin
					wofs_q <= DATA_WORD;
					if (rx_take) begin
						rx_pkt_q <= fnum;
						rst_q <= R_DATA;
					end else if (rx_start_i) begin
						rst_q <= R_DROP;
					end
				end
				R_DATA: begin
					if (rx_ovr) begin
						rst_q <= R_DROP;
					end else begin
						if (rx_word) begin
							mem_we_o <= 1'b1;
							mem_addr_o <= {rx_pkt_q,
								wofs_q[WOFS_W-2:0]};
							mem_wdata_o <= rx_word_i;
							wofs_q <= wofs_q + 1'b1;
						end
						if (rx_end_i) begin
							crc_q <= rx_crc_ok_i;
							rstat_q <= rx_status_i;
							rbytes_q <= rx_bytes_i;
							rst_q <= R_STAT;
						end
					end
				end
				// Rest of a refused or overrun frame is ignored
				R_DROP: begin
					if (rx_end_i) begin
						rst_q <= R_IDLE;
					end
				end
				R_STAT: begin
					mem_we_o <= 1'b1;
					mem_addr_o <= {rx_pkt_q, STAT_WORD[WOFS_W-2:0]};
					mem_wdata_o <= {16'h0000, rstat_q};
					rst_q <= R_CNT;
				end
				R_CNT: begin
					mem_we_o <= 1'b1;
					mem_addr_o <= {rx_pkt_q, CNT_WORD[WOFS_W-2:0]};
					mem_wdata_o <= {16'h0000, rbytes_q};
					rst_q <= R_IDLE;
				end
				default: rst_q <= R_IDLE;
			endcase
		end
	end

	// Transmit queue, completion queue, receive queue
	pkt_queue #(.W(PKT_W), .DEPTH(NPKT), .AW(PKT_W)) u_txq (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.push_i(c_enq), .data_i(pnr_q),
		.pop_i(tx_issue), .data_o(tq_head),
		.empty_o(tq_empty), .full_o(tq_full));
	pkt_queue #(.W(PKT_W), .DEPTH(NPKT), .AW(PKT_W)) u_doneq (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.push_i(dq_push && !dq_full), .data_i(tx_pkt_o),
		.pop_i(c_ack), .data_o(dq_head),
		.empty_o(dq_empty), .full_o(dq_full));
	pkt_queue #(.W(PKT_W), .DEPTH(NPKT), .AW(PKT_W)) u_rxq (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.push_i(rq_push && !rq_full), .data_i(rx_pkt_q),
		.pop_i(c_rxrel), .data_o(rq_head),
		.empty_o(rq_empty), .full_o(rq_full));

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_tx_go_gate: assert property (
		tx_req_o |-> $past(ctrl_q[CTRL_TXGO]) && $past(!tq_empty))
		else $error("send without go or packet");
	a_tx_defer: assert property (
		tx_req_o |-> !$past(ctrl_q[CTRL_HALF]) || $past(tx_defer_ok_i))
		else $error("deferral ignored");
	a_self_free_skip: assert property (
		tx_end && tx_ok_i && ctrl_q[CTRL_SELF] |-> !dq_push
		&& free_mask[tx_pkt_o])
		else $error("self-free skipped");
	a_done_flag: assert property (
		ce_i |=> tx_done_q == $past(!dq_empty))
		else $error("done flag wrong");
	a_drain_flag: assert property (
		ce_i |=> drain_q == $past(tq_empty))
		else $error("drained flag wrong");
	a_fail_stops: assert property (
		tx_end && !tx_ok_i |=> !ctrl_q[CTRL_TXGO] && !tx_busy_q)
		else $error("failure kept sending");
	a_alloc_ok: assert property (
		a_ok |=> alloc_done_q && ares_q == $past(fnum))
		else $error("alloc result missing");
	a_alloc_fail: assert property (
		a_try && !a_ok |=> !alloc_done_q && $stable(ares_q))
		else $error("failed alloc changed result");
	a_rx_accept: assert property (
		rx_take |-> ctrl_q[CTRL_RXGO] && free_q > rsv_q)
		else $error("frame accepted wrongly");
	a_bad_crc: assert property (
		ce_i && rst_q == R_CNT && !crc_q |-> !rq_push
		&& free_mask[rx_pkt_q])
		else $error("bad frame queued or kept");
	a_rx_ready: assert property (
		ce_i |=> rx_rdy_q == $past(!rq_empty && ctrl_q[CTRL_RXIE]))
		else $error("ready flag wrong");
endmodule : pbqm_top

// [test/mac_model.sv]
// Behavioural MAC engine facing the buffer manager's link side.
// Assumes one clock shared with the buffer manager, no clock enable gaps.
`timescale 1ns/1ps
module mac_model import pbqm_pkg::*; #(
	parameter int TX_LAT = 6 // Cycles from hand-off to completion
) (
	input wire logic clk_i,
	input wire logic tx_req_i,
	input wire logic fail_i,
	output logic tx_done_o,
	output logic tx_ok_o,
	output logic [15:0] tx_status_o,
	output logic rx_start_o,
	output logic rx_word_valid_o,
	output logic [31:0] rx_word_o,
	output logic rx_end_o,
	output logic rx_crc_ok_o,
	output logic [15:0] rx_status_o,
	output logic [15:0] rx_bytes_o
);
	localparam logic [15:0] TXS_OK = 16'h0001; // Arbitrary success code
	localparam logic [15:0] TXS_FAIL = 16'h8040; // Arbitrary failure code

	// Quiet levels at time zero
	initial begin
		{tx_done_o, tx_ok_o, rx_start_o, rx_word_valid_o, rx_end_o} = 5'h00;
		{tx_status_o, rx_status_o, rx_bytes_o} = 48'h0;
		{rx_word_o, rx_crc_ok_o} = 33'h0;
	end

	// Answers each hand-off after TX_LAT cycles
	initial begin
		forever begin
			@(posedge clk_i);
			if (tx_req_i === 1'b1) begin
				repeat (TX_LAT) @(posedge clk_i);
				tx_done_o <= 1'b1;
				tx_ok_o <= !fail_i;
				tx_status_o <= fail_i ? TXS_FAIL : TXS_OK;
				@(posedge clk_i);
				tx_done_o <= 1'b0;
				// Qualifiers lose their meaning once done drops
				tx_ok_o <= ~tx_ok_o;
				tx_status_o <= ~tx_status_o;
			end
		end
	end

	// One address-matched frame of nw words, then three quiet cycles
	task send_frame(input int nw, input logic good, input logic [15:0] st);
		int i;
		@(posedge clk_i);
		rx_start_o <= 1'b1;
		for (i = 0; i < nw; i++) begin
			@(posedge clk_i);
			rx_start_o <= 1'b0;
			rx_word_valid_o <= 1'b1;
			rx_word_o <= {16'hC0DE, 16'(i)};
		end
		@(posedge clk_i);
		rx_start_o <= 1'b0;
		rx_word_valid_o <= 1'b0;
		rx_word_o <= ~rx_word_o; // Stale data must not pass as valid
		rx_end_o <= 1'b1;
		rx_crc_ok_o <= good;
		rx_status_o <= st;
		rx_bytes_o <= 16'(nw * 4);
		@(posedge clk_i);
		rx_end_o <= 1'b0;
		rx_crc_ok_o <= ~rx_crc_ok_o;
		rx_status_o <= ~rx_status_o;
		rx_bytes_o <= ~rx_bytes_o;
		// Next start after status and count writes
		repeat (3) @(posedge clk_i);
	endtask : send_frame
endmodule : mac_model

// [test/pbqm_top_tb_top.sv]
// Self-checking bench: AHB-Lite register traffic plus a MAC model.
// Assumes zero-wait-state slave and the register map of the package.
`timescale 1ns/1ps
module pbqm_top_tb_top import pbqm_pkg::*;;
	logic clk_i, rst_i, hwrite_i, tx_defer_ok_i, fail;
	logic [1:0] htrans_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, q, st, rx_word_i, mem_wdata_o;
	logic hreadyout_o, hresp_o, tx_req_o, tx_done_i, tx_ok_i, rx_drop_o;
	logic [PKT_W-1:0] tx_pkt_o, last_pkt, n, p;
	logic [15:0] tx_status_i, rx_status_i, rx_bytes_i;
	logic rx_start_i, rx_word_valid_i, rx_end_i, rx_crc_ok_i, mem_we_o;
	logic [ADDR_W-1:0] mem_addr_o;
	logic [31:0] mem [logic [ADDR_W-1:0]]; // Shadow of packet SRAM
	logic [PKT_W-1:0] pk [16]; // Numbers granted in the fill test
	int err_total, total_checks, tx_cnt, wr_cnt, drop_cnt, k, w0;

	pbqm_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .hsel_i(1'b1),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.tx_req_o(tx_req_o), .tx_pkt_o(tx_pkt_o),
		.tx_defer_ok_i(tx_defer_ok_i), .tx_done_i(tx_done_i),
		.tx_ok_i(tx_ok_i), .tx_status_i(tx_status_i),
		.rx_start_i(rx_start_i), .rx_word_valid_i(rx_word_valid_i),
		.rx_word_i(rx_word_i), .rx_end_i(rx_end_i), .rx_crc_ok_i(rx_crc_ok_i),
		.rx_status_i(rx_status_i), .rx_bytes_i(rx_bytes_i),
		.rx_drop_o(rx_drop_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o));

	mac_model mac (.clk_i(clk_i), .tx_req_i(tx_req_o), .fail_i(fail),
		.tx_done_o(tx_done_i), .tx_ok_o(tx_ok_i), .tx_status_o(tx_status_i),
		.rx_start_o(rx_start_i), .rx_word_valid_o(rx_word_valid_i),
		.rx_word_o(rx_word_i), .rx_end_o(rx_end_i), .rx_crc_ok_o(rx_crc_ok_i),
		.rx_status_o(rx_status_i), .rx_bytes_o(rx_bytes_i));

	// 125 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Link monitors: hand-offs, writes, drops
	always @(posedge clk_i) begin
		if (tx_req_o === 1'b1) begin
			tx_cnt++;
			last_pkt = tx_pkt_o;
		end
		if (mem_we_o === 1'b1) begin
			mem[mem_addr_o] = mem_wdata_o;
			wr_cnt++;
		end
		if (rx_drop_o === 1'b1) drop_cnt++;
	end

	// Compare and count
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One AHB-Lite single word transfer; address held until hready
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= w ? d : ~hwdata_i;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		r = hrdata_o;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	// Read, mask and compare
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(nm, r & m, exp);
	endtask : rchk

	// Poll until masked value matches, bounded
	task wait_reg(input logic [7:0] a, input logic [31:0] m, v);
		logic [31:0] r;
		for (int i = 0; i < 300; i++) begin
			bus(1'b0, a, 32'h0, r);
			if ((r & m) === v) break;
		end
	endtask : wait_reg

	// Allocate nb bytes; st holds the status word that ended the poll
	task alloc(input logic [15:0] nb);
		wr(REG_CMD, {nb, 13'h0, CMD_ALLOC});
		for (int i = 0; i < 50; i++) begin
			bus(1'b0, REG_STAT, 32'h0, st);
			if ((st[ST_ALLOC] | st[ST_AFAIL]) === 1'b1) break;
		end
		n = st[ST_ARES +: PKT_W];
	endtask : alloc

	task end_of_test;
		$display("Checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	// Watchdog far above the run length
	initial begin
		repeat (80000) @(posedge clk_i);
		err_total++;
		$display("ERROR watchdog expected end seen hang");
		end_of_test;
	end

	// Main sequence
	initial begin
		{rst_i, htrans_i, hwrite_i, tx_defer_ok_i, fail} = 6'h20;
		haddr_i = 32'h0;
		hwdata_i = 32'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h0);
		rchk("free", REG_FREE, 32'hFFFFFFFF, 32'h80);
		rchk("drained", REG_STAT, 32'h4, 32'h4);
		chk("okay", 32'(hresp_o), 32'h0);
		wr(8'h40, 32'hFFFFFFFF); // Unmapped place keeps nothing
		rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
		$display("reset done");
		// Use all 16 packet numbers, 6 pages stay free; zero reservation grants all
		for (k = 0; k < 16; k++) begin
			alloc(k == 0 ? 16'd300 : 16'd2048);
			chk("alloc ok", st & 32'h11, 32'h1);
			pk[k] = n;
		end
		rchk("free full", REG_FREE, 32'hFF, 32'h06);
		alloc(16'd256);
		chk("alloc fail", st & 32'h11, 32'h10);
		chk("result kept", 32'(n), 32'(pk[15]));
		for (k = 0; k < 16; k++) begin
			wr(REG_PNR, 32'(pk[k]));
			wr(REG_CMD, 32'(CMD_REL));
		end
		rchk("free back", REG_FREE, 32'hFF, 32'h80);
		$display("alloc done");
		// Hand-off gated by go bit, then deferral
		alloc(16'd64);
		wr(REG_PNR, 32'(n));
		wr(REG_CMD, 32'(CMD_ENQ));
		repeat (30) @(posedge clk_i);
		chk("no go", 32'(tx_cnt), 32'h0);
		rchk("not drained", REG_STAT, 32'h4, 32'h0);
		wr(REG_CTRL, 32'h11); // Go and half duplex
		repeat (30) @(posedge clk_i);
		chk("deferred", 32'(tx_cnt), 32'h0);
		tx_defer_ok_i <= 1'b1;
		wait_reg(REG_STAT, 32'h2, 32'h2);
		chk("sent", 32'(tx_cnt), 32'h1);
		chk("sent pkt", 32'(last_pkt), 32'(n));
		rchk("done drained", REG_STAT, 32'h6, 32'h6);
		rchk("tx head", REG_PORTS, 32'h8F, 32'(n));
		wr(REG_CMD, 32'(CMD_TXACK));
		rchk("done clear", REG_STAT, 32'h2, 32'h0);
		wr(REG_PNR, 32'(n));
		wr(REG_CMD, 32'(CMD_REL));
		$display("tx gate done");
		// Self-freeing, two packets back to back
		wr(REG_CTRL, 32'h05);
		for (k = 0; k < 2; k++) begin
			alloc(16'd700);
			wr(REG_PNR, 32'(n));
			wr(REG_CMD, 32'(CMD_ENQ));
		end
		wait_reg(REG_FREE, 32'hFF, 32'h80);
		chk("two sent", 32'(tx_cnt), 32'h3);
		rchk("self free", REG_STAT, 32'h6, 32'h4);
		// Failure stops transmit, host retries
		alloc(16'd100);
		wr(REG_PNR, 32'(n));
		fail <= 1'b1;
		wr(REG_CMD, 32'(CMD_ENQ));
		wait_reg(REG_STAT, 32'h2, 32'h2);
		rchk("fail done", REG_STAT, 32'h2, 32'h2);
		rchk("go cleared", REG_CTRL, 32'h1, 32'h0);
		rchk("fail pkt", REG_PORTS, 32'h8F, 32'(n));
		rchk("link stat", REG_LINK, 32'hFFFF, 32'(mac.TXS_FAIL));
		fail <= 1'b0;
		wr(REG_CMD, 32'(CMD_TXACK));
		wr(REG_PNR, 32'(n));
		rchk("pnr kept", REG_PNR, 32'hF, 32'(n));
		wr(REG_CTRL, 32'h05);
		wr(REG_CMD, 32'(CMD_ENQ));
		wait_reg(REG_FREE, 32'hFF, 32'h80);
		chk("retry sent", 32'(tx_cnt), 32'h5);
		rchk("retry freed", REG_FREE, 32'hFF, 32'h80);
		$display("tx done");
		// Receive off: frame ignored
		wr(REG_CTRL, 32'h0);
		mac.send_frame(4, 1'b1, 16'h0);
		chk("rx off", 32'(wr_cnt), 32'h0);
		// Two-page frame; reservation raised during it
		wr(REG_CTRL, 32'h0A);
		fork
			mac.send_frame(70, 1'b1, 16'h1234);
			begin
				repeat (20) @(posedge clk_i);
				wr(REG_RSV, 32'hFF);
			end
		join
		wait_reg(REG_STAT, 32'h8, 32'h8);
		rchk("rx ready", REG_STAT, 32'h8, 32'h8);
		bus(1'b0, REG_PORTS, 32'h0, q);
		p = q[PO_RXH +: PKT_W];
		chk("status word", mem[{p, 9'h000}], 32'h1234);
		chk("byte count", mem[{p, 9'h001}] & 32'hFFFF, 32'd280);
		chk("first word", mem[{p, 9'h002}], 32'hC0DE0000);
		chk("last word", mem[{p, 9'h047}], 32'hC0DE0045);
		chk("writes", 32'(wr_cnt), 32'd72);
		rchk("two pages", REG_FREE, 32'hFF, 32'h7E);
		w0 = wr_cnt;
		mac.send_frame(4, 1'b1, 16'h0);
		chk("rsv blocks", 32'(wr_cnt - w0), 32'h0);
		wr(REG_CMD, 32'(CMD_RXREL));
		rchk("released", REG_FREE, 32'hFF, 32'h80);
		rchk("rx empty", REG_PORTS, 32'h8000, 32'h8000);
		wr(REG_RSV, 32'h80);
		w0 = wr_cnt;
		mac.send_frame(4, 1'b1, 16'h0);
		chk("below rsv", 32'(wr_cnt - w0), 32'h0);
		wr(REG_RSV, 32'h0);
		$display("rx done");
		// Ready flag needs interrupt enable
		wr(REG_CTRL, 32'h02);
		mac.send_frame(3, 1'b1, 16'h0);
		rchk("no enable", REG_STAT, 32'h8, 32'h0);
		rchk("queued", REG_PORTS, 32'h8000, 32'h0);
		wr(REG_CTRL, 32'h0A);
		rchk("enabled", REG_STAT, 32'h8, 32'h8);
		wr(REG_CMD, 32'(CMD_RXREL));
		// Bad CRC and overrun both return memory
		mac.send_frame(3, 1'b0, 16'h0);
		rchk("bad crc", REG_STAT, 32'h8, 32'h0);
		rchk("bad freed", REG_FREE, 32'hFF, 32'h80);
		mac.send_frame(520, 1'b1, 16'h0);
		chk("drop pulse", 32'(drop_cnt), 32'h1);
		rchk("drop freed", REG_FREE, 32'hFF, 32'h80);
		rchk("drop empty", REG_PORTS, 32'h8000, 32'h8000);
		$display("rx fault done");
		end_of_test;
	end
endmodule : pbqm_top_tb_top
